// File: rtl/comparator_unit.sv
// Comparator integration shell: register writes, core-clock crossing, debug halt, write guard,
// interrupt and event outputs.
// Assumes the core clock and analog result are asynchronous pins; all else is on the bus clock.
module comparator_unit
  import comparator_pkg::*;
#(
  parameter int CMP_TICKS = 2
) (
  input  wire logic      clock,
  input  wire logic      nrst,
  input  wire logic      comparator_core_clock,
  input  wire logic      cmp_raw,
  input  wire reg_wr_t   wr,
  input  wire logic      guard_lock,
  input  wire logic      cpu_halted,
  input  wire logic      sleeping,
  output reg_view_t      view,
  output logic           wr_refused,
  output logic           irq,
  output logic           wake,
  output logic           cmp_event
);

  localparam int CNT_W = $clog2(CMP_TICKS + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CMP_TICKS - 1);

  logic [1:0]        sync_out;
  logic              core_lvl;
  logic              cmp_lvl;
  logic              core_prev_q;
  logic              tick;
  logic              prot_block;
  logic              busy_block;
  logic              accept;
  logic              halt;
  logic              go;
  logic              done;
  logic              refused_q;
  logic              event_q;
  logic              pend_q;
  logic [DATA_W-1:0] pend_data_q;
  logic [DATA_W-1:0] ctrl_a_q;
  logic [DATA_W-1:0] int_enable_q;
  logic [DATA_W-1:0] debug_run_q;
  logic [FLAG_W-1:0] flag_q;
  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] flag_clr;
  logic              start_q;
  logic              result_q;
  logic [CNT_W-1:0]  cnt_q;
  cmp_state_t        state_q;

  input_sync #(
    .W (2)
  ) u_sync (
    .clock (clock),
    .nrst  (nrst),
    .din   ({comparator_core_clock, cmp_raw}),
    .dout  (sync_out)
  );

  assign core_lvl = sync_out[1];
  assign cmp_lvl  = sync_out[0];

  // Core clock rising edge seen in the bus domain; sleep does not gate it
  always_ff @(posedge clock) begin
    if (!nrst) begin
      core_prev_q <= 1'b0;
    end else begin
      core_prev_q <= core_lvl;
    end
  end

  assign tick = core_lvl & ~core_prev_q;

  assign prot_block = guard_lock && !wr.debugger && guarded(wr.sel);
  assign busy_block = (wr.sel == SEL_CTRL_A) && pend_q;
  assign accept     = wr.valid && !prot_block && !busy_block;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= wr.valid && !accept;
    end
  end

  // Control A waits for the next core clock edge before it takes effect
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pend_q      <= 1'b0;
      pend_data_q <= CTRL_A_RESET;
      ctrl_a_q    <= CTRL_A_RESET;
    end else begin
      if (accept && wr.sel == SEL_CTRL_A) begin
        pend_q      <= 1'b1;
        pend_data_q <= wr.data;
      end else if (pend_q && tick) begin
        pend_q   <= 1'b0;
        ctrl_a_q <= pend_data_q;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      int_enable_q <= INT_ENABLE_RESET;
      debug_run_q  <= DEBUG_RUN_RESET;
    end else if (accept) begin
      if (wr.sel == SEL_INT_ENABLE) begin
        int_enable_q <= wr.data;
      end
      if (wr.sel == SEL_DEBUG_RUN) begin
        debug_run_q <= wr.data;
      end
    end
  end

  assign halt = cpu_halted && !debug_run_q[DEBUG_RUN_BIT];
  assign go   = tick && ctrl_a_q[CTRL_A_ENABLE_BIT] && !halt
                && (ctrl_a_q[CTRL_A_CONT_BIT] || start_q);
  assign done = (state_q == ST_CMP) && tick && (cnt_q == CNT_LAST);

  // Single-shot start request; a new request in the start cycle is kept
  always_ff @(posedge clock) begin
    if (!nrst) begin
      start_q <= 1'b0;
    end else if (accept && wr.sel == SEL_SECOND_CONTROL && wr.data[START_BIT]) begin
      start_q <= 1'b1;
    end else if (go && state_q == ST_IDLE) begin
      start_q <= 1'b0;
    end
  end

  // A comparison in progress runs to its end even under debug halt
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q  <= ST_IDLE;
      cnt_q    <= '0;
      result_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go) begin
            state_q <= ST_CMP;
            cnt_q   <= '0;
          end
        end
        ST_CMP: begin
          if (done) begin
            state_q  <= ST_DONE;
            result_q <= cmp_lvl;
          end else if (tick) begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    flag_set                  = '0;
    flag_set[FLAG_DONE_BIT]   = done;
    flag_set[FLAG_TOGGLE_BIT] = done && (cmp_lvl != result_q);
    flag_clr                  = '0;
    if (accept && wr.sel == SEL_INT_FLAG) begin
      flag_clr = wr.data[FLAG_W-1:0];
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      flag_q <= FLAG_RESET;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      event_q <= 1'b0;
    end else begin
      event_q <= done;
    end
  end

  assign irq        = |(flag_q & int_enable_q[FLAG_W-1:0]);
  assign wake       = irq && sleeping;
  assign cmp_event  = event_q;
  assign wr_refused = refused_q;

  always_comb begin
    view            = '0;
    view.ctrl_a     = ctrl_a_q;
    view.int_enable = int_enable_q;
    view.int_flag   = flag_q;
    view.debug_run  = debug_run_q;
    view.sync_busy  = pend_q;
    view.result     = result_q;
  end

endmodule : comparator_unit

// File: rtl/comparator_pkg.sv
// Constants, register selectors, field layouts and carrier types for the comparator shell.
// Assumes one bus clock; the core clock and the analog result arrive as asynchronous inputs.
//
// Contract
// - The unit keeps comparing in every sleep mode while its selected core clock keeps running.
// - Comparator interrupt requests can wake the device out of sleep.
// - Comparator events go to the event routing system without the device leaving sleep.
// - Writes to the core-clocked control register cross into the core clock domain through synchronization.
// - The interrupt request output goes to the interrupt controller, which software configures first.
// - When the processor halts in debug mode the unit finishes a comparison in progress and then stops.
// - A debug run control bit lets the unit keep running while the processor is halted.
// - Every writable register can be write-protected by the guard except the second control and flag registers.
// - Accesses from an external debugger bypass the write guard.
package comparator_pkg;

  localparam int DATA_W = 8;
  localparam int FLAG_W = 2;

  localparam logic [DATA_W-1:0] CTRL_A_RESET     = 8'h00;
  localparam logic [DATA_W-1:0] INT_ENABLE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DEBUG_RUN_RESET  = 8'h00;
  localparam logic [FLAG_W-1:0] FLAG_RESET       = 2'h0;

  localparam int CTRL_A_ENABLE_BIT = 0;
  localparam int CTRL_A_CONT_BIT   = 1;
  localparam int START_BIT         = 0;
  localparam int DEBUG_RUN_BIT     = 0;
  localparam int FLAG_DONE_BIT     = 0;
  localparam int FLAG_TOGGLE_BIT   = 1;

  typedef enum logic [2:0] {
    SEL_CTRL_A         = 3'h0,
    SEL_SECOND_CONTROL = 3'h1,
    SEL_INT_ENABLE     = 3'h2,
    SEL_INT_FLAG       = 3'h3,
    SEL_DEBUG_RUN      = 3'h4
  } reg_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMP  = 2'b01,
    ST_DONE = 2'b11
  } cmp_state_t;

  typedef struct packed {
    logic              valid;
    reg_sel_t          sel;
    logic [DATA_W-1:0] data;
    logic              debugger;
  } reg_wr_t;

  typedef struct packed {
    logic [DATA_W-1:0] ctrl_a;
    logic [DATA_W-1:0] int_enable;
    logic [FLAG_W-1:0] int_flag;
    logic [DATA_W-1:0] debug_run;
    logic              sync_busy;
    logic              result;
  } reg_view_t;

  // Second control and flag registers are never guarded
  function automatic logic guarded(input reg_sel_t sel);
    guarded = (sel != SEL_SECOND_CONTROL) && (sel != SEL_INT_FLAG);
  endfunction : guarded

endpackage : comparator_pkg

// File: rtl/input_sync.sv
// Three-stage synchroniser for asynchronous inputs with agreement filter.
// Assumes the input is quasi-static relative to the bus clock.
module input_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit changes only once stages two and three agree
  always_ff @(posedge clock) begin
    if (!nrst) begin
      out_q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          out_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign dout = out_q;

endmodule : input_sync

// File: bench/comparator_asserts.sv
// Port-level assertions for the comparator shell.
// Assumes it is bound to comparator_unit and sees only its ports.
module comparator_asserts
  import comparator_pkg::*;
#(
  parameter int CMP_TICKS = 2
) (
  input wire logic      clock,
  input wire logic      nrst,
  input wire logic      comparator_core_clock,
  input wire logic      cmp_raw,
  input wire reg_wr_t   wr,
  input wire logic      guard_lock,
  input wire logic      cpu_halted,
  input wire logic      sleeping,
  input wire reg_view_t view,
  input wire logic      wr_refused,
  input wire logic      irq,
  input wire logic      wake,
  input wire logic      cmp_event
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic locked;
  assign locked = wr.valid && guard_lock && !wr.debugger;

  AST_WAKE: assert property (wake == (irq && sleeping))
    else $error("wake mismatch");
  AST_IRQ: assert property (irq == |(view.int_flag & view.int_enable[1:0]))
    else $error("irq mismatch");
  AST_LOCKED: assert property (locked && wr.sel inside {SEL_CTRL_A, SEL_INT_ENABLE, SEL_DEBUG_RUN}
    |=> wr_refused && $stable(view.int_enable)) else $error("guarded write taken");
  AST_OPEN: assert property (wr.valid && wr.sel inside {SEL_SECOND_CONTROL, SEL_INT_FLAG} |=> !wr_refused)
    else $error("open write refused");
  AST_DEBUGGER: assert property (wr.valid && wr.debugger && wr.sel == SEL_INT_ENABLE
    |=> !wr_refused && view.int_enable == $past(wr.data)) else $error("debugger write lost");
  AST_BUSY: assert property (!locked && wr.valid && wr.sel == SEL_CTRL_A && !view.sync_busy |=> view.sync_busy)
    else $error("busy not raised");
  AST_BUSY_REFUSE: assert property (view.sync_busy && wr.valid && wr.sel == SEL_CTRL_A |=> wr_refused)
    else $error("write while busy taken");
  AST_APPLY: assert property ($changed(view.ctrl_a) |-> $fell(view.sync_busy))
    else $error("control applied outside crossing");
  AST_EVENT: assert property ($rose(view.int_flag[0]) |-> cmp_event ##1 !cmp_event)
    else $error("event pulse wrong");
endmodule : comparator_asserts

bind comparator_unit comparator_asserts #(.CMP_TICKS(CMP_TICKS)) u_asserts (.clock(clock), .nrst(nrst),
  .comparator_core_clock(comparator_core_clock), .cmp_raw(cmp_raw), .wr(wr), .guard_lock(guard_lock),
  .cpu_halted(cpu_halted), .sleeping(sleeping), .view(view), .wr_refused(wr_refused), .irq(irq),
  .wake(wake), .cmp_event(cmp_event));

// File: bench/comparator_far_side.sv
// Far side of the comparator shell: core clock source and event sink.
// Assumes the bench turns the clock on once it counts as configured.
module comparator_far_side (
  input  wire logic clock,
  input  wire logic clk_on,
  input  wire logic cmp_event,
  output logic      core_clk,
  output int        events
);
  timeunit 1ns;
  timeprecision 100ps;
  initial core_clk = 1'b0;
  initial events = 0;
  // Core clock stands low until enabled
  always #125 core_clk = clk_on ? ~core_clk : 1'b0;
  always @(posedge clock) if (cmp_event) events <= events + 1;
endmodule : comparator_far_side

// File: bench/tb_comparator_unit.sv
// Self-checking bench for comparator_unit: crossing, guard, sleep wake, events, debug halt.
// Assumes the far-side model supplies the core clock and counts events.
module tb_comparator_unit;
  import comparator_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic      clock, nrst, clk_on, cmp_raw, guard_lock, cpu_halted, sleeping;
  logic      wr_refused, irq, wake, cmp_event, core_clk;
  reg_wr_t   wr;
  reg_view_t view;
  int        events, err_total, check_count, n, base;

  comparator_far_side far (.clock(clock), .clk_on(clk_on), .cmp_event(cmp_event), .core_clk(core_clk),
    .events(events));
  comparator_unit #(.CMP_TICKS(1)) DUT (.clock(clock), .nrst(nrst), .comparator_core_clock(core_clk),
    .cmp_raw(cmp_raw), .wr(wr), .guard_lock(guard_lock), .cpu_halted(cpu_halted), .sleeping(sleeping),
    .view(view), .wr_refused(wr_refused), .irq(irq), .wake(wake), .cmp_event(cmp_event));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // One write; refusal is seen in the cycle after it is taken
  task automatic put(input reg_sel_t sel, input logic [7:0] data, input logic dbg, input logic refused);
    wr <= '{1'b1, sel, data, dbg};
    @(negedge clock);
    chk("refused", {7'h00, refused}, {7'h00, wr_refused});
    wr.valid <= 1'b0;
    @(negedge clock);
  endtask : put

  task automatic wait_for(input bit busy);
    for (n = 0; n < 400 && (busy ? view.sync_busy : events == base); n++) @(negedge clock);
    if (n == 400) begin
      $display("ERROR wait expected done seen timeout");
      err_total++;
      report_and_stop();
    end
  endtask : wait_for

  task automatic t_reset();
    chk("view", 8'h00, {7'h00, |view});
    chk("outputs", 8'h00, {4'h0, irq, wake, cmp_event, wr_refused});
    $display("reset test done");
  endtask : t_reset

  task automatic t_cross();
    put(SEL_CTRL_A, 8'h01, 1'b0, 1'b0);
    chk("sync_busy", 8'h01, {7'h00, view.sync_busy});
    put(SEL_CTRL_A, 8'h03, 1'b0, 1'b1);
    chk("ctrl_a held", 8'h00, view.ctrl_a);
    clk_on = 1'b1;
    wait_for(1'b1);
    chk("ctrl_a", 8'h01, view.ctrl_a);
    $display("crossing test done");
  endtask : t_cross

  task automatic t_sleep();
    put(SEL_INT_ENABLE, 8'h01, 1'b0, 1'b0);
    sleeping = 1'b1;
    guard_lock = 1'b1;
    cmp_raw = 1'b1;
    base = events;
    put(SEL_SECOND_CONTROL, 8'h01, 1'b0, 1'b0);
    wait_for(1'b0);
    repeat (2) @(negedge clock);
    chk("result", 8'h01, {7'h00, view.result});
    chk("irq wake", 8'h03, {6'h00, irq, wake});
    chk("flags set", 8'h03, {6'h00, view.int_flag});
    put(SEL_INT_FLAG, 8'h03, 1'b0, 1'b0);
    chk("flags", 8'h00, {4'h0, view.int_flag, irq, wake});
    sleeping = 1'b0;
    $display("sleep test done");
  endtask : t_sleep

  task automatic t_guard();
    put(SEL_INT_ENABLE, 8'h02, 1'b0, 1'b1);
    put(SEL_DEBUG_RUN, 8'h01, 1'b0, 1'b1);
    chk("guarded", 8'h01, view.int_enable | view.debug_run);
    put(SEL_INT_ENABLE, 8'h02, 1'b1, 1'b0);
    chk("int_enable", 8'h02, view.int_enable);
    guard_lock = 1'b0;
    $display("guard test done");
  endtask : t_guard

  task automatic t_halt();
    cpu_halted = 1'b1;
    base = events;
    put(SEL_SECOND_CONTROL, 8'h01, 1'b0, 1'b0);
    repeat (60) @(negedge clock);
    chk("halted events", base[7:0], events[7:0]);
    put(SEL_DEBUG_RUN, 8'h01, 1'b0, 1'b0);
    chk("debug_run", 8'h01, view.debug_run);
    put(SEL_SECOND_CONTROL, 8'h01, 1'b0, 1'b0);
    wait_for(1'b0);
    cpu_halted = 1'b0;
    put(SEL_DEBUG_RUN, 8'h00, 1'b0, 1'b0);
    repeat (30) @(negedge clock);
    base = events;
    put(SEL_SECOND_CONTROL, 8'h01, 1'b0, 1'b0);
    // Halt lands after the comparison has started on the next core edge
    for (n = 0; n < 20 && core_clk; n++) @(negedge clock);
    for (n = 0; n < 20 && !core_clk; n++) @(negedge clock);
    chk("core clock", 8'h01, {7'h00, core_clk});
    if (!core_clk) report_and_stop();
    repeat (7) @(negedge clock);
    cpu_halted = 1'b1;
    wait_for(1'b0);
    chk("in-progress events", base[7:0] + 8'h01, events[7:0]);
    cpu_halted = 1'b0;
    $display("halt test done");
  endtask : t_halt

  task automatic t_cont();
    put(SEL_CTRL_A, 8'h03, 1'b0, 1'b0);
    wait_for(1'b1);
    chk("ctrl_a cont", 8'h03, view.ctrl_a);
    base = events;
    wait_for(1'b0);
    base = events;
    wait_for(1'b0);
    chk("cont result", 8'h01, {7'h00, view.result});
    $display("continuous test done");
  endtask : t_cont

  initial begin
    {clk_on, cmp_raw, guard_lock, cpu_halted, sleeping, nrst} = '0;
    wr = '0;
    err_total = 0;
    check_count = 0;
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    t_reset();
    t_cross();
    t_sleep();
    t_guard();
    t_halt();
    t_cont();
    report_and_stop();
  end
endmodule : tb_comparator_unit
